// *** core/rwss_pkg.sv ***
package rwss_pkg;

  // Register byte offsets.
  localparam logic [7:0] RWSS_CTRL_OFS = 8'h00;
  localparam logic [7:0] RWSS_STAT_OFS = 8'h04;
  localparam logic [7:0] RWSS_WORD_OFS = 8'h08;
  localparam logic [7:0] RWSS_MASK_OFS = 8'h0c;

  // Control fields.
  localparam int RWSS_GEN_EN_BIT = 2;
  localparam int RWSS_IRQ_EN_BIT = 3;
  localparam logic [31:0] RWSS_CTRL_RESET = 32'h0000_0000;

  // Status fields; the mask register shares this layout.
  localparam int RWSS_READY_BIT = 0;
  localparam int RWSS_CLK_NOW_BIT = 1;
  localparam int RWSS_SEED_NOW_BIT = 2;
  localparam int RWSS_CLK_STICKY_BIT = 5;
  localparam int RWSS_SEED_STICKY_BIT = 6;
  localparam logic [31:0] RWSS_MASK_RESET = 32'h0000_0061;
  localparam logic [31:0] RWSS_WORD_RESET = 32'h0000_0000;

  // Timing and detection limits.
  localparam int RWSS_CLK_RATIO = 16;
  localparam int RWSS_GEN_PERIODS = 42;
  localparam int RWSS_CONST_RUN_LIMIT = 64;
  localparam int RWSS_ALT_PAIR_LIMIT = 32;
  localparam int RWSS_ALT_BIT_LIMIT = 2 * RWSS_ALT_PAIR_LIMIT;
  localparam int RWSS_NOISE_SOURCES = 2;

  localparam logic [1:0] RWSS_HTRANS_NONSEQ = 2'b10;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } rwss_access_type;

  typedef enum logic [1:0] {
    RWSS_GEN_COLLECT = 2'b01,
    RWSS_GEN_HOLD = 2'b10
  } rwss_gen_state_type;

endpackage : rwss_pkg

// *** core/rwss_top.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - Sticky seed fault bit 6 sets with the current seed fault; zero write clears.
// - Sticky clock fault bit 5 sets with the current clock fault; zero write clears.
// - Either sticky fault with its mask bit (5 or 6) and interrupt enable set holds the interrupt pending.
// - Current clock fault bit 1 is high while generator clock is below bus clock over 16.
// - Current seed fault bit 2 on over 64 equal bits or over 32 alternating pairs.
// - Current seed fault clears when the condition ends; sticky stays.
// - Current clock fault clears when the clock recovers; sticky stays.
// - Ready bit 0 is one only while the data register holds a valid word.
// - Reading the data register drops ready until a fresh word is made.
// - Ready with mask bit 0 and interrupt enable set raises the interrupt.
// - Read-only 32-bit data register at offset 0x008; writes do nothing.
// - After a data read a new word follows after 42 generator clock periods.
// - A ready word stays valid and readable after generator enable is cleared.
// - The data register reads zero while ready is low.
module rwss_top (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  input wire logic gen_clk_in,
  input wire logic [rwss_pkg::RWSS_NOISE_SOURCES-1:0] noise_bits_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic irq_out
);
  import rwss_pkg::*;

  function automatic logic [6:0] sat_inc(input logic [6:0] v);
    sat_inc = (v == 7'h7f) ? v : v + 7'h01;
  endfunction : sat_inc

  rwss_access_type acc;
  logic [31:0] ctrl;
  logic [31:0] mask;
  logic clk_sticky;
  logic seed_sticky;
  logic clk_fault_now;
  logic seed_now_q;
  logic [31:0] shift;
  logic [31:0] word;
  logic [5:0] gen_cnt;
  rwss_gen_state_type gen_state;
  logic gclk_s1, gclk_s2, gclk_s3;
  logic [RWSS_NOISE_SOURCES-1:0] noise_s1, noise_s2, noise_prev;
  logic [6:0] const_run [RWSS_NOISE_SOURCES];
  logic [6:0] alt_run [RWSS_NOISE_SOURCES];
  logic [6:0] clk_cnt;

  // Bus decode. Size is not checked: only whole words are used on this port.
  wire addr_phase = hsel_in & hready_in & (htrans_in == RWSS_HTRANS_NONSEQ);
  wire [7:0] addr_lo = {haddr_in[7:2], 2'b00};
  wire rd_word = addr_phase & ~hwrite_in & (addr_lo == RWSS_WORD_OFS);
  wire wr_ctrl = acc.valid & acc.write & (acc.addr == RWSS_CTRL_OFS);
  wire wr_stat = acc.valid & acc.write & (acc.addr == RWSS_STAT_OFS);
  wire wr_mask = acc.valid & acc.write & (acc.addr == RWSS_MASK_OFS);
  wire gen_edge = gclk_s2 & ~gclk_s3;
  wire gen_en = ctrl[RWSS_GEN_EN_BIT];
  wire word_ready = (gen_state == RWSS_GEN_HOLD);

  logic [RWSS_NOISE_SOURCES-1:0] src_fault;
  always_comb begin
    for (int i = 0; i < RWSS_NOISE_SOURCES; i++) begin
      src_fault[i] = (const_run[i] > 7'(RWSS_CONST_RUN_LIMIT)) | (alt_run[i] > 7'(RWSS_ALT_BIT_LIMIT));
    end
  end
  wire seed_fault_now = |src_fault;

  wire clk_fault_next = (clk_cnt > 7'(RWSS_CLK_RATIO));

  // The current flags are registered so that each one shows in the same cycle as its sticky twin.
  wire [31:0] status = {25'h0, seed_sticky, clk_sticky, 2'b00, seed_now_q, clk_fault_now, word_ready};
  wire [31:0] word_view = word_ready ? word : 32'h0000_0000;
  wire [31:0] next_hrdata = (addr_lo == RWSS_CTRL_OFS) ? ctrl :
                            (addr_lo == RWSS_STAT_OFS) ? status :
                            (addr_lo == RWSS_WORD_OFS) ? word_view :
                            (addr_lo == RWSS_MASK_OFS) ? mask : 32'h0000_0000;

  // Set wins over a zero write; a one write leaves the bit alone.
  wire next_seed_sticky = seed_fault_now |
                          (seed_sticky & ~(wr_stat & ~hwdata_in[RWSS_SEED_STICKY_BIT]));
  wire next_clk_sticky = clk_fault_next |
                         (clk_sticky & ~(wr_stat & ~hwdata_in[RWSS_CLK_STICKY_BIT]));
  wire [31:0] pend = {25'h0, seed_sticky, clk_sticky, 4'h0, word_ready} & mask;
  wire next_irq = ctrl[RWSS_IRQ_EN_BIT] & (|pend);

  wire mix_bit = (^noise_s2) ^ shift[31] ^ shift[21] ^ shift[1] ^ shift[0];

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      acc <= '0;
      hrdata_out <= 32'h0000_0000;
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end else begin
      acc <= '{valid: addr_phase, write: hwrite_in, addr: addr_lo};
      if (addr_phase && !hwrite_in) begin
        hrdata_out <= next_hrdata;
      end
    end
  end

  // The data register has no write path at all.
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl <= RWSS_CTRL_RESET;
      mask <= RWSS_MASK_RESET;
      seed_sticky <= 1'b0;
      clk_sticky <= 1'b0;
      seed_now_q <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      seed_now_q <= seed_fault_now;
      if (wr_ctrl) begin
        ctrl <= hwdata_in & ((32'h1 << RWSS_GEN_EN_BIT) | (32'h1 << RWSS_IRQ_EN_BIT));
      end
      if (wr_mask) begin
        mask <= hwdata_in & RWSS_MASK_RESET;
      end
      seed_sticky <= next_seed_sticky;
      clk_sticky <= next_clk_sticky;
      irq_out <= next_irq;
    end
  end

  // The generator clock is only sampled: it is much slower than the bus clock by design.
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      gclk_s1 <= 1'b0;
      gclk_s2 <= 1'b0;
      gclk_s3 <= 1'b0;
      noise_s1 <= '0;
      noise_s2 <= '0;
    end else begin
      gclk_s1 <= gen_clk_in;
      gclk_s2 <= gclk_s1;
      gclk_s3 <= gclk_s2;
      noise_s1 <= noise_bits_in;
      noise_s2 <= noise_s1;
    end
  end

  // Bus cycles since the last generator edge; too many means the clock is too slow.
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      clk_cnt <= 7'h00;
      clk_fault_now <= 1'b0;
    end else begin
      clk_cnt <= gen_edge ? 7'h01 : sat_inc(clk_cnt);
      clk_fault_now <= clk_fault_next;
    end
  end

  // Run-length health tests, one pair of counters per noise source.
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      noise_prev <= '0;
      for (int i = 0; i < RWSS_NOISE_SOURCES; i++) begin
        const_run[i] <= 7'h00;
        alt_run[i] <= 7'h00;
      end
    end else if (gen_edge && gen_en) begin
      noise_prev <= noise_s2;
      for (int i = 0; i < RWSS_NOISE_SOURCES; i++) begin
        const_run[i] <= (noise_s2[i] == noise_prev[i]) ? sat_inc(const_run[i]) : 7'h01;
        alt_run[i] <= (noise_s2[i] != noise_prev[i]) ? sat_inc(alt_run[i]) : 7'h01;
      end
    end
  end

  // Word assembly. A held word survives a cleared enable; only a data read releases it.
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      gen_state <= RWSS_GEN_COLLECT;
      gen_cnt <= 6'h00;
      shift <= 32'h0000_0000;
      word <= RWSS_WORD_RESET;
    end else begin
      case (gen_state)
        RWSS_GEN_COLLECT: begin
          if (gen_edge && gen_en) begin
            shift <= {shift[30:0], mix_bit};
            if (gen_cnt == 6'(RWSS_GEN_PERIODS - 1)) begin
              gen_state <= RWSS_GEN_HOLD;
              word <= {shift[30:0], mix_bit};
              gen_cnt <= 6'h00;
            end else begin
              gen_cnt <= gen_cnt + 6'h01;
            end
          end
        end
        RWSS_GEN_HOLD: begin
          if (rd_word) begin
            gen_state <= RWSS_GEN_COLLECT;
            word <= RWSS_WORD_RESET;
          end
        end
        default: begin
          gen_state <= RWSS_GEN_COLLECT;
        end
      endcase
    end
  end

endmodule : rwss_top

// *** bench/rwss_assertions.sv ***
`timescale 1ns/1ps
module rwss_checker (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  input wire logic [31:0] hrdata_out,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  input wire logic irq_out
);
  import rwss_pkg::*;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);
  logic ap;
  logic wr_ctl;
  logic ie_q;
  assign ap = hsel_in && hready_in && htrans_in == RWSS_HTRANS_NONSEQ;
  // Shadow of the interrupt enable, updated at the same data-phase edge as the real control bit.
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_ctl <= 1'b0;
      ie_q <= 1'b0;
    end else begin
      wr_ctl <= ap && hwrite_in && haddr_in[7:2] == 6'h0;
      ie_q <= wr_ctl ? hwdata_in[RWSS_IRQ_EN_BIT] : ie_q;
    end
  end
  sequence rd(a);
    ap && !hwrite_in && haddr_in[7:0] == a;
  endsequence
  a_resp_okay: assert property (hresp_out == 1'b0 && hreadyout_out == 1'b1) else $error("bad response");
  a_rdata_hold: assert property (!(ap && !hwrite_in) |=> $stable(hrdata_out)) else $error("read data moved");
  a_unmapped_zero: assert property (ap && !hwrite_in && haddr_in[7:0] >= 8'h10 |=> hrdata_out == 32'h0)
    else $error("unmapped read not zero");
  a_stat_reserved: assert property (rd(RWSS_STAT_OFS) |=> (hrdata_out & 32'hffff_ff98) == 32'h0)
    else $error("status reserved bits set");
  a_reread_zero: assert property (rd(RWSS_WORD_OFS) ##1 rd(RWSS_WORD_OFS) |=> hrdata_out == 32'h0)
    else $error("second word read not zero");
  a_seed_sticky: assert property (rd(RWSS_STAT_OFS) |=> !hrdata_out[2] || hrdata_out[6])
    else $error("seed fault without sticky");
  a_clk_sticky: assert property (rd(RWSS_STAT_OFS) |=> !hrdata_out[1] || hrdata_out[5])
    else $error("clock fault without sticky");
  a_irq_gate: assert property (!ie_q |=> !irq_out) else $error("interrupt while disabled");
endmodule : rwss_checker

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  import rwss_pkg::*;
  logic mclk_in = 0, rstn_in = 0, hsel_in = 0, hwrite_in = 0, gen_clk_in = 0, gen_run = 1;
  logic [31:0] haddr_in = 0, hwdata_in = 0, hrdata_out, rd;
  logic [1:0] htrans_in = 0, noise_bits_in = 0, nmode = 0;
  logic [7:0] gcnt = 0;
  logic hreadyout_out, hresp_out, irq_out;
  int err_total = 0, samples_checked = 0;
  always #5 mclk_in = ~mclk_in;
  rwss_top uut (.mclk_in(mclk_in), .rstn_in(rstn_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
    .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(3'h2), .hwdata_in(hwdata_in),
    .hready_in(hreadyout_out), .gen_clk_in(gen_clk_in), .noise_bits_in(noise_bits_in),
    .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .irq_out(irq_out));
  // Generator clock at a quarter of the bus clock, well above the one-sixteenth limit.
  always @(posedge mclk_in) if (gen_run) begin
    gcnt <= gcnt + 8'h1;
    gen_clk_in <= gcnt[1];
    noise_bits_in <= nmode == 1 ? 2'b11 : nmode == 2 ? {2{gcnt[2]}} : {gcnt[2] ^ gcnt[5], gcnt[3] ^ gcnt[4]};
  end
  task print_verdict;
    if (err_total == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict
  task cyc(input int n);
    repeat (n) @(posedge mclk_in);
  endtask : cyc
  task wrdy;
    @(posedge mclk_in);
    while (hreadyout_out !== 1'b1) @(posedge mclk_in);
  endtask : wrdy
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel_in <= 1'b1;
    htrans_in <= RWSS_HTRANS_NONSEQ;
    hwrite_in <= w;
    haddr_in <= {24'h0, a};
    wrdy;
    htrans_in <= 2'b00;
    hwdata_in <= d;
    wrdy;
    rd = hrdata_out;
  endtask : xfer
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask : rdc
  initial begin
    #200us;
    err_total++;
    print_verdict;
  end
  initial begin
    cyc(8);
    rstn_in <= 1'b1;
    cyc(1);
    rdc(RWSS_CTRL_OFS, 32'hffff_ffff, RWSS_CTRL_RESET);
    rdc(RWSS_MASK_OFS, 32'hffff_ffff, RWSS_MASK_RESET);
    rdc(RWSS_STAT_OFS, 32'h1, 32'h0);
    rdc(RWSS_WORD_OFS, 32'hffff_ffff, RWSS_WORD_RESET);
    rdc(8'h10, 32'hffff_ffff, 32'h0);
    xfer(1'b1, RWSS_CTRL_OFS, 32'h4);
    cyc(180);
    rdc(RWSS_STAT_OFS, 32'h67, 32'h1);
    xfer(1'b1, RWSS_WORD_OFS, 32'hffff_ffff);
    rdc(RWSS_STAT_OFS, 32'h1, 32'h1);
    // Generator off with a word pending: the word must survive.
    xfer(1'b1, RWSS_CTRL_OFS, 32'h8);
    cyc(2);
    chk({31'h0, irq_out}, 32'h1);
    rdc(RWSS_STAT_OFS, 32'h1, 32'h1);
    xfer(1'b0, RWSS_WORD_OFS, 32'h0);
    rdc(RWSS_STAT_OFS, 32'h1, 32'h0);
    rdc(RWSS_WORD_OFS, 32'hffff_ffff, 32'h0);
    chk({31'h0, irq_out}, 32'h0);
    xfer(1'b1, RWSS_CTRL_OFS, 32'hc);
    cyc(150);
    rdc(RWSS_STAT_OFS, 32'h1, 32'h0);
    cyc(40);
    rdc(RWSS_STAT_OFS, 32'h1, 32'h1);
    xfer(1'b1, RWSS_MASK_OFS, 32'h20);
    gen_run <= 1'b0;
    cyc(30);
    rdc(RWSS_STAT_OFS, 32'h22, 32'h22);
    chk({31'h0, irq_out}, 32'h1);
    gen_run <= 1'b1;
    cyc(20);
    rdc(RWSS_STAT_OFS, 32'h22, 32'h20);
    xfer(1'b1, RWSS_STAT_OFS, 32'h60);
    rdc(RWSS_STAT_OFS, 32'h20, 32'h20);
    xfer(1'b1, RWSS_STAT_OFS, 32'h0);
    rdc(RWSS_STAT_OFS, 32'h22, 32'h0);
    cyc(2);
    chk({31'h0, irq_out}, 32'h0);
    nmode <= 2'd1;
    cyc(300);
    rdc(RWSS_STAT_OFS, 32'h44, 32'h44);
    nmode <= 2'd0;
    cyc(40);
    rdc(RWSS_STAT_OFS, 32'h44, 32'h40);
    xfer(1'b1, RWSS_STAT_OFS, 32'h0);
    nmode <= 2'd2;
    cyc(300);
    rdc(RWSS_STAT_OFS, 32'h44, 32'h44);
    print_verdict;
  end
endmodule : tb_top
bind rwss_top rwss_checker chk_i (.mclk_in(mclk_in), .rstn_in(rstn_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
  .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hwdata_in(hwdata_in), .hready_in(hready_in),
  .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .irq_out(irq_out));
